/* rtl/rlc_ladder_ctrl.sv */
// module: reference ladder control register with apb slave and pin override
// Function
// - bit 7 powers the reference ladder on when one and down when zero.
// - bit 6 routes the selected level onto the shared port a pin, zero disconnects it.
// - while bit 6 is set the pin is taken over regardless of the port a direction bit.
// - bit 5 picks the low range (one, step vdd/24) or middle range (zero, step vdd/32).
// - bits 3 to 0 select one of 16 taps within the chosen range.
// - low range tap is code over 24, middle range tap is code plus 8 over 32.
// - bit 4 is unimplemented, ignores writes and reads as zero.
`timescale 1ns/100ps
module rlc_ladder_ctrl
  import rlc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port_a_direction,
  output logic ladder_power_on,
  output logic level_pin_drive,
  output logic range_select,
  output logic [3:0] level_code,
  output logic [4:0] tap_index,
  output logic [5:0] tap_divisor,
  output logic pin_dir_effective
);
  rlc_state_t state_reg;
  rlc_state_t state_next;
  logic hit;
  logic access;
  logic wr_fire;
  logic rd_fire;
  logic strobe_miss;

  rlc_sel_if sel ();

  // read view of the control byte: spare position always zero
  function automatic logic [7:0] rlc_visible(input logic [7:0] raw);
    rlc_visible = raw & RLC_CTRL_WMASK;
  endfunction

  function automatic logic [31:0] rlc_word(input logic [7:0] raw);
    rlc_word = {RLC_PAD_ZERO, rlc_visible(raw)};
  endfunction

  assign hit = (paddr == RLC_CTRL_ADDR);
  assign access = psel & penable;
  assign wr_fire = access & pwrite & hit & pstrb[RLC_STRB_LANE];
  assign rd_fire = access & ~pwrite & hit;
  assign strobe_miss = access & pwrite & hit & ~pstrb[RLC_STRB_LANE];

  always_comb begin
    state_next = state_reg;
    // direction pin comes from outside the clock domain: first stage feeds only the second
    state_next.dir_s1 = port_a_direction;
    state_next.dir_s2 = state_reg.dir_s1;
    if (wr_fire) begin
      // spare bit masked so it never stores
      state_next.ctrl = rlc_visible(pwdata[RLC_CTRL_BYTE_MSB:0]);
    end
    if (rd_fire) begin
      state_next.rdata = rlc_word(state_reg.ctrl);
    end else if (access) begin
      state_next.rdata = RLC_ZERO_WORD;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '{ctrl: RLC_CTRL_RESET, rdata: RLC_ZERO_WORD, dir_s1: RLC_DIR_INPUT, dir_s2: RLC_DIR_INPUT};
    end else begin
      state_reg <= state_next;
    end
  end

  // zero-wait slave: read data is muxed straight from the register in the access phase
  assign pready = 1'b1;
  assign pslverr = access & ~hit;
  assign prdata = rd_fire ? rlc_word(state_reg.ctrl) : state_reg.rdata;

  assign ladder_power_on = state_reg.ctrl[RLC_POWER_BIT];
  assign level_pin_drive = state_reg.ctrl[RLC_PIN_BIT];
  assign range_select = state_reg.ctrl[RLC_RANGE_BIT];
  assign level_code = state_reg.ctrl[RLC_LEVEL_MSB:RLC_LEVEL_LSB];
  // pin drive forces the pin away from digital output regardless of direction bit
  assign pin_dir_effective = level_pin_drive ? RLC_DIR_INPUT : state_reg.dir_s2;

  assign sel.range_select = range_select;
  assign sel.level_code = level_code;
  assign tap_index = sel.tap_index;
  assign tap_divisor = sel.tap_divisor;

  rlc_tap_decode u_dec (
    .sel(sel)
  );

  default clocking cb_chk @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_ctrl_write;
    wr_fire;
  endsequence

  sequence s_ctrl_read;
    rd_fire;
  endsequence

  sequence s_unmapped_access;
    access && !hit;
  endsequence

  sequence s_no_ctrl_write;
    !wr_fire;
  endsequence

  // direction input unchanged over three samples
  sequence s_dir_settled;
    $stable(port_a_direction) ##1 $stable(port_a_direction);
  endsequence

  chk_spare_reads_zero: assert property (
    access || !access
    |-> !state_reg.ctrl[RLC_SPARE_BIT]
  ) else $error("spare bit stored");

  chk_write_reaches_out: assert property (
    s_ctrl_write
    |=> ladder_power_on == $past(pwdata[RLC_POWER_BIT]) && level_code == $past(pwdata[RLC_LEVEL_MSB:RLC_LEVEL_LSB])
  ) else $error("write not applied");

  chk_power_on_write: assert property (
    s_ctrl_write ##0 pwdata[RLC_POWER_BIT]
    |=> ladder_power_on
  ) else $error("ladder not powered on");

  chk_power_down_write: assert property (
    s_ctrl_write ##0 !pwdata[RLC_POWER_BIT]
    |=> !ladder_power_on
  ) else $error("ladder not powered down");

  chk_power_hold: assert property (
    s_no_ctrl_write
    |=> $stable(ladder_power_on)
  ) else $error("power changed without write");

  chk_pin_route_bit: assert property (
    s_ctrl_write ##0 pwdata[RLC_PIN_BIT]
    |=> level_pin_drive
  ) else $error("pin drive missing");

  chk_pin_release_bit: assert property (
    s_ctrl_write ##0 !pwdata[RLC_PIN_BIT]
    |=> !level_pin_drive
  ) else $error("pin drive not released");

  chk_pin_hold: assert property (
    s_no_ctrl_write
    |=> $stable(level_pin_drive)
  ) else $error("pin drive changed without write");

  chk_pin_override_dir: assert property (
    level_pin_drive
    |-> pin_dir_effective == RLC_DIR_INPUT
  ) else $error("override lost");

  chk_dir_follows_pin: assert property (
    !level_pin_drive
    |-> pin_dir_effective == $past(port_a_direction, 2)
  ) else $error("direction not passed through");

  chk_dir_settled_pass: assert property (
    s_dir_settled ##0 !level_pin_drive
    |-> pin_dir_effective == port_a_direction
  ) else $error("settled direction not seen");

  chk_range_low_write: assert property (
    s_ctrl_write ##0 pwdata[RLC_RANGE_BIT]
    |=> range_select
  ) else $error("low range not selected");

  chk_range_mid_write: assert property (
    s_ctrl_write ##0 !pwdata[RLC_RANGE_BIT]
    |=> !range_select
  ) else $error("middle range not selected");

  chk_range_hold: assert property (
    s_no_ctrl_write
    |=> $stable(range_select)
  ) else $error("range changed without write");

  chk_low_range_div: assert property (
    range_select
    |-> tap_divisor == {1'b0, RLC_LOW_DIV}
  ) else $error("low range step wrong");

  chk_mid_range_div: assert property (
    !range_select
    |-> tap_divisor == RLC_MID_DIV
  ) else $error("middle range step wrong");

  chk_tap_div_legal: assert property (
    access || !access
    |-> tap_divisor == {1'b0, RLC_LOW_DIV} || tap_divisor == RLC_MID_DIV
  ) else $error("step divisor illegal");

  chk_level_from_write: assert property (
    s_ctrl_write
    |=> level_code == $past(pwdata[RLC_LEVEL_MSB:RLC_LEVEL_LSB])
  ) else $error("level code not stored");

  chk_level_hold: assert property (
    s_no_ctrl_write
    |=> $stable(level_code)
  ) else $error("level changed without write");

  chk_low_tap_max: assert property (
    range_select
    |-> tap_index <= {1'b0, RLC_LEVEL_MAX}
  ) else $error("low range tap out of range");

  chk_mid_tap_min: assert property (
    !range_select
    |-> tap_index >= RLC_MID_OFFSET
  ) else $error("middle range tap out of range");

  chk_low_range_tap: assert property (
    range_select
    |-> tap_index == {1'b0, level_code}
  ) else $error("low range tap wrong");

  chk_mid_range_tap: assert property (
    !range_select
    |-> tap_index == {1'b0, level_code} + RLC_MID_OFFSET
  ) else $error("mid range tap wrong");

  chk_spare_write_drop: assert property (
    s_ctrl_write ##0 pwdata[RLC_SPARE_BIT]
    |=> !state_reg.ctrl[RLC_SPARE_BIT]
  ) else $error("spare write stored");

  chk_read_spare_zero: assert property (
    s_ctrl_read
    |-> !prdata[RLC_SPARE_BIT]
  ) else $error("spare bit read as one");

  chk_read_upper_zero: assert property (
    s_ctrl_read
    |-> prdata[RLC_WORD_MSB:RLC_PAD_LSB] == RLC_PAD_ZERO
  ) else $error("upper read bits not zero");

  chk_read_fields: assert property (
    s_ctrl_read
    |-> prdata[RLC_POWER_BIT] == ladder_power_on && prdata[RLC_PIN_BIT] == level_pin_drive
        && prdata[RLC_RANGE_BIT] == range_select && prdata[RLC_LEVEL_MSB:RLC_LEVEL_LSB] == level_code
  ) else $error("read data differs from fields");

  chk_write_fields_all: assert property (
    s_ctrl_write
    |=> state_reg.ctrl == ($past(pwdata[RLC_CTRL_BYTE_MSB:0]) & RLC_CTRL_WMASK)
  ) else $error("written byte not stored");

  chk_read_reg_capture: assert property (
    s_ctrl_read
    |=> state_reg.rdata == $past(prdata)
  ) else $error("read data not held");

  chk_read_no_side: assert property (
    s_ctrl_read
    |=> $stable(state_reg.ctrl)
  ) else $error("read changed control");

  chk_pready_high: assert property (
    access
    |-> pready
  ) else $error("wait state inserted");

  chk_unmapped_no_store: assert property (
    s_unmapped_access
    |=> $stable(state_reg.ctrl)
  ) else $error("unmapped write stored");

  chk_unmapped_err: assert property (
    s_unmapped_access
    |-> pslverr
  ) else $error("unmapped access not flagged");

  chk_mapped_no_err: assert property (
    access && hit
    |-> !pslverr
  ) else $error("mapped access flagged");

  chk_strobe_gate: assert property (
    strobe_miss
    |=> $stable(state_reg.ctrl)
  ) else $error("unstrobed write stored");
endmodule

/* rtl/rlc_pkg.sv */
// package: register map, field layout and tap constants for the reference ladder control
package rlc_pkg;
  localparam logic [11:0] RLC_CTRL_ADDR = 12'h000;
  localparam logic [7:0] RLC_CTRL_RESET = 8'h00;
  localparam int RLC_POWER_BIT = 7;
  localparam int RLC_PIN_BIT = 6;
  localparam int RLC_RANGE_BIT = 5;
  localparam int RLC_SPARE_BIT = 4;
  localparam int RLC_LEVEL_MSB = 3;
  localparam int RLC_LEVEL_LSB = 0;
  localparam int RLC_CTRL_BYTE_MSB = 7;
  localparam int RLC_STRB_LANE = 0;
  localparam int RLC_WORD_MSB = 31;
  localparam int RLC_PAD_LSB = 8;
  localparam logic [23:0] RLC_PAD_ZERO = 24'h000000;
  localparam logic RLC_DIR_INPUT = 1'b1;
  localparam logic [3:0] RLC_LEVEL_MAX = 4'hF;
  localparam logic [7:0] RLC_CTRL_WMASK = 8'hEF;
  localparam logic [4:0] RLC_MID_OFFSET = 5'h08;
  localparam logic [4:0] RLC_LOW_DIV = 5'h18;
  localparam logic [5:0] RLC_MID_DIV = 6'h20;
  localparam int RLC_PIN_INDEX = 2;
  localparam logic [31:0] RLC_ZERO_WORD = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [31:0] rdata;
    logic dir_s1;
    logic dir_s2;
  } rlc_state_t;
endpackage

/* rtl/rlc_sel_if.sv */
// interface: control fields passed from register file to tap decoder
`timescale 1ns/100ps
interface rlc_sel_if;
  logic range_select;
  logic [3:0] level_code;
  logic [4:0] tap_index;
  logic [5:0] tap_divisor;
  modport ctrl (output range_select, output level_code, input tap_index, input tap_divisor);
  modport dec (input range_select, input level_code, output tap_index, output tap_divisor);
endinterface

/* rtl/rlc_tap_decode.sv */
// module: maps level code and range to ladder tap numerator and divisor
`timescale 1ns/100ps
module rlc_tap_decode
  import rlc_pkg::*;
(
  rlc_sel_if.dec sel
);
  function automatic logic [4:0] rlc_tap(input logic range_sel, input logic [3:0] code);
    if (range_sel) begin
      rlc_tap = {1'b0, code};
    end else begin
      rlc_tap = {1'b0, code} + RLC_MID_OFFSET;
    end
  endfunction

  // low range: code * vdd/24, middle range: (code + 8) * vdd/32
  assign sel.tap_index = rlc_tap(sel.range_select, sel.level_code);
  assign sel.tap_divisor = sel.range_select ? {1'b0, RLC_LOW_DIV} : RLC_MID_DIV;
endmodule

/* sim/rlc_ladder_ctrl_tb.sv */
// testbench: apb access and ladder outputs of the reference ladder control
`timescale 1ns/100ps
module rlc_ladder_ctrl_tb;
  import rlc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, port_a_direction = 1, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hF, level_code;
  logic pready, pslverr, ladder_power_on, level_pin_drive, range_select, pin_dir_effective;
  logic [4:0] tap_index;
  logic [5:0] tap_divisor;
  int err_count = 0, cmp_count = 0, cyc = 0;
  always #10 pclk = ~pclk;
  rlc_ladder_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_a_direction(port_a_direction), .ladder_power_on(ladder_power_on), .level_pin_drive(level_pin_drive),
    .range_select(range_select), .level_code(level_code), .tap_index(tap_index), .tap_divisor(tap_divisor),
    .pin_dir_effective(pin_dir_effective));
  // bounds a hung handshake
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 8000) begin
      err_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    #1;
  endtask
  task automatic t_reset();
    apb(0, RLC_CTRL_ADDR, 0, 4'hF);
    chk("ctrl reset", 32'h0, rd);
    chk("outs reset", {1'b0, 1'b0, 1'b0, 4'h0, 5'h08, 6'h20}, {ladder_power_on, level_pin_drive, range_select,
      level_code, tap_index, tap_divisor});
    chk("dir reset", 1'b1, pin_dir_effective);
    $display("test reset done");
  endtask
  task automatic t_taps();
    logic [7:0] v;
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 16; c++) begin
        v = {1'b1, 1'b0, r[0], 1'b1, c[3:0]};
        apb(1, RLC_CTRL_ADDR, {24'hFFFFFF, v}, 4'h1);
        chk("fields", {1'b1, 1'b0, r[0], c[3:0]}, {ladder_power_on, level_pin_drive, range_select, level_code});
        chk("tap", r ? c : c + 8, tap_index);
        chk("divisor", r ? 24 : 32, tap_divisor);
        apb(0, RLC_CTRL_ADDR, 0, 4'hF);
        chk("readback", {24'h0, v & RLC_CTRL_WMASK}, rd);
      end
    end
    apb(1, RLC_CTRL_ADDR, 0, 4'hF);
    chk("power off", 1'b0, ladder_power_on);
    $display("test taps done");
  endtask
  task automatic t_pin();
    @(posedge pclk);
    port_a_direction <= 0;
    repeat (4) @(posedge pclk);
    #1;
    chk("dir passes", 1'b0, pin_dir_effective);
    apb(1, RLC_CTRL_ADDR, 32'h40, 4'hF);
    chk("pin drive", 2'b11, {level_pin_drive, pin_dir_effective});
    apb(1, RLC_CTRL_ADDR, 0, 4'hF);
    chk("pin release", 2'b00, {level_pin_drive, pin_dir_effective});
    @(posedge pclk);
    port_a_direction <= 1;
    repeat (4) @(posedge pclk);
    #1;
    chk("dir back", 1'b1, pin_dir_effective);
    $display("test pin done");
  endtask
  task automatic t_refuse();
    apb(1, RLC_CTRL_ADDR, 32'h25, 4'hF);
    apb(1, RLC_CTRL_ADDR, 32'h8A, 4'hE);
    chk("no strobe", 1'b0, ladder_power_on);
    apb(1, 12'h004, 32'hFF, 4'hF);
    chk("unmapped err", 1'b1, err);
    apb(0, 12'h004, 0, 4'hF);
    chk("unmapped read", 32'h0, rd);
    apb(0, RLC_CTRL_ADDR, 0, 4'hF);
    chk("ctrl kept", 32'h25, rd);
    $display("test refuse done");
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    t_reset();
    t_taps();
    t_pin();
    t_refuse();
    summarize();
  end
endmodule
